// File: spfa_pkg.sv
/*
  Shared constants for the serial host-port frame handler: frame layout,
  block-select encoding, memory geometry and reset values.
  Assumes a single 25 MHz ref_clk domain; the serial clock is sampled as data.
*/
package spfa_pkg;

  localparam int BYTE_W = 8;
  localparam int ADDR_W = 16;
  localparam int MEM_AW = 14;
  localparam int MEM_DEPTH = 16384;
  localparam int SOCK_OFS_W = 11;

  // Control byte field positions
  localparam int CTRL_BSB_HI = 7;
  localparam int CTRL_BSB_LO = 3;
  localparam int CTRL_RW_POS = 2;
  localparam int CTRL_LEN_HI = 1;

  localparam logic [1:0] LEN_VARIABLE = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

  localparam logic [2:0] CNT_ONE = 3'h1;
  localparam logic [2:0] CNT_TWO = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;
  localparam logic [2:0] BIT_LAST = 3'h7;

  localparam logic [1:0] BLK_COMMON = 2'h0;
  localparam logic [1:0] BLK_SOCK_REG = 2'h1;
  localparam logic [1:0] BLK_TX_BUF = 2'h2;
  localparam logic [1:0] BLK_RX_BUF = 2'h3;
  localparam logic [4:0] BSB_COMMON = 5'h00;

  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_ADDR_HI = 2'b00,
    ST_ADDR_LO = 2'b01,
    ST_CTRL = 2'b11,
    ST_DATA = 2'b10
  } spfa_state_t;

endpackage

// File: spfa_link_if.sv
/*
  Byte-level link between the serial shifter and the frame handler.
  Both ends run on ref_clk.
*/
`timescale 1ns/100ps
interface spfa_link_if;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic frame_idle;
  logic [7:0] tx_byte;
  logic tx_load;

  modport shifter (output rx_byte, output rx_valid, output frame_idle,
                   input tx_byte, input tx_load);
  modport handler (input rx_byte, input rx_valid, input frame_idle,
                   output tx_byte, output tx_load);
endinterface

// File: spfa_shifter.sv
/*
  Serial shifter: synchronises the serial pins into ref_clk, finds serial
  clock edges and moves bytes in and out.
  Assumes the serial clock idles low and runs at most ref_clk/8.
*/
`timescale 1ns/100ps
module spfa_shifter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic serial_chip_select_n,
  output logic miso,
  output logic miso_oe_n,
  // Byte side
  spfa_link_if.shifter link
);
  logic sclk_s1_r, sclk_s2_r, sclk_d_r;
  logic mosi_s1_r, mosi_s2_r;
  logic cs_s1_r, cs_s2_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] in_sh_r;
  logic [7:0] out_sh_r;
  logic rise, fall;

  // Pins pass two flops before any logic looks at them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r <= 1'b0;
      mosi_s1_r <= 1'b0;
      mosi_s2_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
    end else begin
      sclk_s1_r <= sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r <= sclk_s2_r;
      mosi_s1_r <= mosi;
      mosi_s2_r <= mosi_s1_r;
      cs_s1_r <= serial_chip_select_n;
      cs_s2_r <= cs_s1_r;
    end
  end

  assign rise = sclk_s2_r & ~sclk_d_r;
  assign fall = ~sclk_s2_r & sclk_d_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 3'h0;
      in_sh_r <= spfa_pkg::BYTE_RST;
    end else if (cs_s2_r) begin
      bit_cnt_r <= 3'h0;
    end else if (rise) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      in_sh_r <= {in_sh_r[6:0], mosi_s2_r};
    end
  end

  assign link.rx_valid = rise & ~cs_s2_r & (bit_cnt_r == spfa_pkg::BIT_LAST);
  assign link.rx_byte = {in_sh_r[6:0], mosi_s2_r};
  assign link.frame_idle = cs_s2_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_r <= spfa_pkg::BYTE_RST;
      miso <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= cs_s2_r;
      if (link.tx_load) begin
        out_sh_r <= link.tx_byte;
      end else if (fall) begin
        miso <= out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end
endmodule

// File: spfa_frame.sv
/*
  Frame handler for the serial host port: parses address and control
  phases, routes data bytes to registers or socket buffers.
  Assumes serial mode 0; register contents live outside and answer
  one ref_clk cycle after a request.
*/
`timescale 1ns/100ps
module spfa_frame (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic serial_chip_select_n,
  output logic miso,
  output logic miso_oe_n,
  // Register block port
  output logic reg_req_r,
  output logic reg_we_r,
  output logic reg_common_r,
  output logic [2:0] reg_socket_r,
  output logic [15:0] reg_addr_r,
  output logic [7:0] reg_wdata_r,
  input wire logic [7:0] reg_rdata,
  // Network side of the buffers
  input wire logic [13:0] net_tx_rd_addr,
  output logic [7:0] net_tx_rd_data_r,
  input wire logic net_rx_wr_en,
  input wire logic [13:0] net_rx_wr_addr,
  input wire logic [7:0] net_rx_wr_data,
  // Status
  output logic fixed_length_mode_r
);
  spfa_link_if link ();

  spfa_shifter u_shifter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .mosi(mosi),
    .serial_chip_select_n(serial_chip_select_n),
    .miso(miso),
    .miso_oe_n(miso_oe_n),
    .link(link)
  );

  logic [7:0] tx_mem [spfa_pkg::MEM_DEPTH];
  logic [7:0] rx_mem [spfa_pkg::MEM_DEPTH];

  spfa_pkg::spfa_state_t state_r;
  logic [15:0] addr_r;
  logic [4:0] block_select_field_r;
  logic read_write_bit_r;
  logic [1:0] transfer_length_field_r;
  logic [2:0] remain_r;
  logic [2:0] len_bytes;

  logic acc_go;
  logic acc_we;
  logic [4:0] acc_bsb;
  logic [15:0] acc_addr;

  logic go_r;
  logic go_we_r;
  logic [1:0] go_type_r;
  logic [13:0] go_idx_r;
  logic [7:0] go_wdata_r;
  logic load_r;
  logic [1:0] load_type_r;
  logic load_valid_r;
  logic [7:0] tx_q_r;
  logic [7:0] rx_q_r;
  logic acc_valid;
  logic more_data;

  always_comb begin
    case (link.rx_byte[spfa_pkg::CTRL_LEN_HI:0])
      spfa_pkg::LEN_ONE: len_bytes = spfa_pkg::CNT_ONE;
      spfa_pkg::LEN_TWO: len_bytes = spfa_pkg::CNT_TWO;
      default: len_bytes = spfa_pkg::CNT_FOUR;
    endcase
  end

  // variable mode streams, fixed mode counts down
  assign more_data = (transfer_length_field_r == spfa_pkg::LEN_VARIABLE) ||
                     (remain_r != spfa_pkg::CNT_ONE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= spfa_pkg::ST_ADDR_HI;
      addr_r <= spfa_pkg::ADDR_RST;
      block_select_field_r <= spfa_pkg::BSB_COMMON;
      read_write_bit_r <= 1'b0;
      transfer_length_field_r <= spfa_pkg::LEN_VARIABLE;
      remain_r <= 3'h0;
    end else if (link.frame_idle) begin
      // release of chip select ends any frame
      state_r <= spfa_pkg::ST_ADDR_HI;
    end else if (link.rx_valid) begin
      case (state_r)
        spfa_pkg::ST_ADDR_HI: begin
          addr_r[15:8] <= link.rx_byte;
          state_r <= spfa_pkg::ST_ADDR_LO;
        end
        spfa_pkg::ST_ADDR_LO: begin
          addr_r[7:0] <= link.rx_byte;
          state_r <= spfa_pkg::ST_CTRL;
        end
        spfa_pkg::ST_CTRL: begin
          block_select_field_r <= link.rx_byte[spfa_pkg::CTRL_BSB_HI:spfa_pkg::CTRL_BSB_LO];
          read_write_bit_r <= link.rx_byte[spfa_pkg::CTRL_RW_POS];
          transfer_length_field_r <= link.rx_byte[spfa_pkg::CTRL_LEN_HI:0];
          remain_r <= len_bytes;
          state_r <= spfa_pkg::ST_DATA;
        end
        spfa_pkg::ST_DATA: begin
          addr_r <= addr_r + 16'h0001;
          remain_r <= remain_r - 3'h1;
          if (!more_data) begin
            state_r <= spfa_pkg::ST_ADDR_HI;
          end
        end
        default: state_r <= spfa_pkg::ST_ADDR_HI;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fixed_length_mode_r <= 1'b0;
    end else if (link.rx_valid && state_r == spfa_pkg::ST_CTRL) begin
      fixed_length_mode_r <= link.rx_byte[spfa_pkg::CTRL_LEN_HI:0] != spfa_pkg::LEN_VARIABLE;
    end
  end

  // Reads prefetch the next byte so it is loaded before the next falling edge
  always_comb begin
    acc_go = 1'b0;
    acc_we = 1'b0;
    acc_bsb = block_select_field_r;
    acc_addr = addr_r;
    if (link.rx_valid && !link.frame_idle) begin
      if (state_r == spfa_pkg::ST_CTRL && !link.rx_byte[spfa_pkg::CTRL_RW_POS]) begin
        acc_go = 1'b1;
        acc_bsb = link.rx_byte[spfa_pkg::CTRL_BSB_HI:spfa_pkg::CTRL_BSB_LO];
      end else if (state_r == spfa_pkg::ST_DATA && read_write_bit_r) begin
        acc_go = 1'b1;
        acc_we = 1'b1;
      end else if (state_r == spfa_pkg::ST_DATA && more_data) begin
        acc_go = 1'b1;
        acc_addr = addr_r + 16'h0001;
      end
    end
  end

  // common block needs socket bits zero
  assign acc_valid = (acc_bsb[1:0] != spfa_pkg::BLK_COMMON) ||
                     (acc_bsb == spfa_pkg::BSB_COMMON);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_r <= 1'b0;
      go_we_r <= 1'b0;
      go_type_r <= spfa_pkg::BLK_COMMON;
      go_idx_r <= 14'h0000;
      go_wdata_r <= spfa_pkg::BYTE_RST;
    end else begin
      go_r <= acc_go & acc_valid;
      go_we_r <= acc_we;
      go_type_r <= acc_bsb[1:0];
      // socket n owns 2KB slice; any offset wraps into it
      go_idx_r <= {acc_bsb[4:2], acc_addr[spfa_pkg::SOCK_OFS_W-1:0]};
      go_wdata_r <= link.rx_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_req_r <= 1'b0;
      reg_we_r <= 1'b0;
      reg_common_r <= 1'b0;
      reg_socket_r <= 3'h0;
      reg_addr_r <= spfa_pkg::ADDR_RST;
      reg_wdata_r <= spfa_pkg::BYTE_RST;
    end else begin
      // socket upper bits, type lower bits
      reg_req_r <= acc_go & acc_valid & ~acc_bsb[1];
      reg_we_r <= acc_we;
      reg_common_r <= acc_bsb[1:0] == spfa_pkg::BLK_COMMON;
      reg_socket_r <= acc_bsb[4:2];
      reg_addr_r <= acc_addr;
      reg_wdata_r <= link.rx_byte;
    end
  end

  // transmit memory, host writes, network reads
  always_ff @(posedge ref_clk) begin
    if (go_r && go_we_r && go_type_r == spfa_pkg::BLK_TX_BUF) begin
      tx_mem[go_idx_r] <= go_wdata_r;
    end
    tx_q_r <= tx_mem[go_idx_r];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      net_tx_rd_data_r <= spfa_pkg::BYTE_RST;
    end else begin
      net_tx_rd_data_r <= tx_mem[net_tx_rd_addr];
    end
  end

  // receive memory, network writes, host reads only
  always_ff @(posedge ref_clk) begin
    if (net_rx_wr_en) begin
      rx_mem[net_rx_wr_addr] <= net_rx_wr_data;
    end
    rx_q_r <= rx_mem[go_idx_r];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_r <= 1'b0;
      load_type_r <= spfa_pkg::BLK_COMMON;
      load_valid_r <= 1'b0;
    end else begin
      load_r <= (go_r & ~go_we_r) | (acc_go & ~acc_we & ~acc_valid);
      load_type_r <= go_type_r;
      load_valid_r <= go_r;
    end
  end

  // read byte handed to shifter; reserved blocks read zero
  assign link.tx_load = load_r;
  always_comb begin
    link.tx_byte = spfa_pkg::BYTE_RST;
    if (load_valid_r) begin
      case (load_type_r)
        spfa_pkg::BLK_TX_BUF: link.tx_byte = tx_q_r;
        spfa_pkg::BLK_RX_BUF: link.tx_byte = rx_q_r;
        default: link.tx_byte = reg_rdata;
      endcase
    end
  end
endmodule

// File: spfa_frame_assertions.sv
/* Checker on the frame handler pins.
   Assumes one ref_clk domain. */
`timescale 1ns/100ps
module spfa_frame_assertions (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Serial pins
  input wire logic sclk,
  input wire logic serial_chip_select_n,
  input wire logic miso,
  input wire logic miso_oe_n,
  // Register port, status
  input wire logic reg_req_r,
  input wire logic reg_we_r,
  input wire logic [15:0] reg_addr_r,
  input wire logic fixed_length_mode_r
);
  logic sclk_q;
  logic [3:0] rise_q;
  logic [3:0] fall_q;
  logic [7:0] gap_q;
  logic [15:0] last_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Cycles since serial clock edges and since the last request
  always_ff @(posedge ref_clk) sclk_q <= sclk;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (sclk && !sclk_q)) rise_q <= 4'h0;
    else if (rise_q != 4'hf) rise_q <= rise_q + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (!sclk && sclk_q)) fall_q <= 4'h0;
    else if (fall_q != 4'hf) fall_q <= fall_q + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || reg_req_r) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  always_ff @(posedge ref_clk) begin
    if (reg_req_r) last_q <= reg_addr_r;
  end
  sequence s_cs_held;
    serial_chip_select_n [*4];
  endsequence
  sequence s_after_rise;
    rise_q >= 4'h1 && rise_q <= 4'h7;
  endsequence
  property p_cs_quiet;
    s_cs_held |-> miso_oe_n && !reg_req_r;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("port active while deselected");
  property p_req_gap;
    reg_req_r |=> !reg_req_r [*7];
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("requests too close");
  // Gaps inside one frame are near 64 cycles, between frames above 190
  property p_addr_step;
    reg_req_r && gap_q < 8'h78 |-> reg_addr_r == last_q + 16'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("offset did not step by one");
  property p_wr_time;
    reg_req_r && reg_we_r |-> s_after_rise;
  endproperty
  a_wr_time: assert property (p_wr_time)
    else $error("write not tied to a clock rise");
  property p_rd_time;
    reg_req_r && !reg_we_r |-> s_after_rise;
  endproperty
  a_rd_time: assert property (p_rd_time)
    else $error("read not tied to a clock rise");
  property p_mode_time;
    $changed(fixed_length_mode_r) |-> s_after_rise;
  endproperty
  a_mode_time: assert property (p_mode_time)
    else $error("mode flag moved off a rise");
  property p_miso_time;
    $changed(miso) && !miso_oe_n |-> fall_q >= 4'h1 && fall_q <= 4'h6;
  endproperty
  a_miso_time: assert property (p_miso_time)
    else $error("data out moved off a fall");
  property p_reset_clean;
    $rose(rst_n) |-> miso_oe_n && !reg_req_r && !fixed_length_mode_r;
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("not idle after reset");
endmodule

// File: spfa_host.sv
/* Host model: mode 0 serial master.
   Assumes edges on ref_clk falls, 8 cycles a bit. */
`timescale 1ns/100ps
module spfa_host (
  // Timing
  input wire logic ref_clk,
  // Serial pins
  output logic sclk,
  output logic mosi,
  output logic serial_chip_select_n,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    serial_chip_select_n = 1'b1;
  end
  task automatic select();
    @(negedge ref_clk);
    serial_chip_select_n = 1'b0;
  endtask
  task automatic release_select();
    @(negedge ref_clk);
    serial_chip_select_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    serial_chip_select_n = 1'b0;
  endtask
  task automatic frame(input logic [15:0] ofs, input logic [4:0] bsb, input logic rw,
                       input logic [1:0] len, input logic [31:0] wd, output logic [31:0] rd);
    int nb;
    logic [63:0] v;
    logic [63:0] s;
    // only 1, 2 or 4 bytes after offset and control
    // Variable length frames carry two bytes; the caller then releases chip select
    nb = (len == 2'h3) ? 4 : (len == 2'h0) ? 2 : int'(len);
    v = ({40'h0, ofs, bsb, rw, len} << (8 * nb)) | {32'h0, wd};
    s = 64'h0;
    for (int i = 24 + 8 * nb - 1; i >= 0; i--) begin
      // shift on the fall, sample on the rise
      @(negedge ref_clk);
      sclk = 1'b0;
      mosi = v[i];
      repeat (4) @(negedge ref_clk);
      sclk = 1'b1;
      s = {s[62:0], miso};
      repeat (3) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    sclk = 1'b0;
    // Idle data line never shows a stale level
    mosi = ~mosi;
    rd = s[31:0] & ~(32'hffffffff << (8 * nb));
  endtask
endmodule

// File: spfa_frame_tb_top.sv
/* Bench: host model on the pins, register block and network port here.
   Assumes chip select held low after start, apart from one 8-cycle release. */
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module spfa_frame_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, mosi, serial_chip_select_n, miso, miso_oe_n;
  logic reg_req_r, reg_we_r, reg_common_r, fixed_length_mode_r;
  logic [2:0] reg_socket_r;
  logic [15:0] reg_addr_r;
  logic [7:0] reg_wdata_r, net_tx_rd_data_r;
  logic [7:0] reg_rdata = 8'h00;
  logic [7:0] ans = 8'h00;
  logic req_seen = 1'b0;
  logic [13:0] net_tx_rd_addr = 14'h0000;
  logic [13:0] net_rx_wr_addr = 14'h0000;
  logic [7:0] net_rx_wr_data = 8'h00;
  logic net_rx_wr_en = 1'b0;
  logic [27:0] wq[$];
  logic [31:0] rd;
  logic miso_pin;
  // Released data line shows the inverse of the last level
  assign miso_pin = miso_oe_n ? ~miso : miso;
  int fails = 0;
  int samples_checked = 0;
  spfa_frame spfa_frame_i (.ref_clk, .rst_n, .sclk, .mosi, .serial_chip_select_n, .miso,
    .miso_oe_n, .reg_req_r, .reg_we_r, .reg_common_r, .reg_socket_r, .reg_addr_r,
    .reg_wdata_r, .reg_rdata, .net_tx_rd_addr, .net_tx_rd_data_r, .net_rx_wr_en,
    .net_rx_wr_addr, .net_rx_wr_data, .fixed_length_mode_r);
  spfa_host spfa_host_i (.ref_clk, .sclk, .mosi, .serial_chip_select_n, .miso(miso_pin));
  initial forever #20 ref_clk = ~ref_clk;
  // Register block answers the cycle after a request, toggles otherwise
  always @(negedge ref_clk) begin
    req_seen <= (reg_req_r === 1'b1);
    ans <= {reg_socket_r, 5'h00} ^ reg_addr_r[7:0];
    reg_rdata <= req_seen ? ans : ~reg_rdata;
    if (reg_req_r === 1'b1 && reg_we_r === 1'b1)
      wq.push_back({reg_common_r, reg_socket_r, reg_addr_r, reg_wdata_r});
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge ref_clk);
    fails++;
    stop_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    spfa_host_i.select();
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      net_rx_wr_en = 1'b1;
      net_rx_wr_addr = 14'h1900 + 14'(i);
      net_rx_wr_data = 8'haa + 8'(17 * i);
      @(negedge ref_clk);
      net_rx_wr_en = 1'b0;
    end
    spfa_host_i.frame(16'h0018, 5'h00, 1'b1, 2'h2, 32'ha53c, rd);
    spfa_host_i.frame(16'h0040, 5'h06, 1'b1, 2'h3, 32'h11223344, rd);
    spfa_host_i.frame(16'h0100, 5'h0f, 1'b1, 2'h1, 32'h77, rd);
    spfa_host_i.frame(16'h0000, 5'h08, 1'b1, 2'h1, 32'h99, rd);
    spfa_host_i.frame(16'h0020, 5'h00, 1'b1, 2'h0, 32'h5a6b, rd);
    spfa_host_i.release_select();
    `CHK("variable mode flag", 1'b0, fixed_length_mode_r);
    spfa_host_i.frame(16'h0003, 5'h1d, 1'b0, 2'h3, 32'h0, rd);
    `CHK("socket register read", 32'he3e4e5e6, rd);
    spfa_host_i.frame(16'hf841, 5'h06, 1'b0, 2'h2, 32'h0, rd);
    `CHK("tx buffer read", 32'h2233, rd);
    spfa_host_i.frame(16'h0100, 5'h0f, 1'b0, 2'h3, 32'h0, rd);
    `CHK("rx buffer read", 32'haabbccdd, rd);
    spfa_host_i.frame(16'h0000, 5'h08, 1'b0, 2'h1, 32'h0, rd);
    `CHK("reserved read", 32'h0, rd);
    `CHK("mode flag", 1'b1, fixed_length_mode_r);
    `CHK("write count", 4, wq.size());
    `CHK("first write", {1'b1, 3'h0, 16'h0018, 8'ha5}, wq[0]);
    `CHK("second write", {1'b1, 3'h0, 16'h0019, 8'h3c}, wq[1]);
    `CHK("variable first write", {1'b1, 3'h0, 16'h0020, 8'h5a}, wq[2]);
    `CHK("variable second write", {1'b1, 3'h0, 16'h0021, 8'h6b}, wq[3]);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      net_tx_rd_addr = 14'h0840 + 14'(i);
      repeat (2) @(negedge ref_clk);
      `CHK("tx memory", 8'h11 * 8'(i + 1), net_tx_rd_data_r);
    end
    stop_test();
  end
endmodule
bind spfa_frame spfa_frame_assertions spfa_frame_assertions_i (.ref_clk, .rst_n, .sclk,
  .serial_chip_select_n, .miso, .miso_oe_n, .reg_req_r, .reg_we_r, .reg_addr_r,
  .fixed_length_mode_r);
